// file: bdtc_discard_timer.sv
`timescale 1ns/100ps

module bdtc_discard_timer #(
    parameter int CNT_W = bdtc_pkg::DISCARD_CNT_W,
    parameter int LONG_CYCLES = bdtc_pkg::DISCARD_LONG_CYCLES,
    parameter int SHORT_CYCLES = bdtc_pkg::DISCARD_SHORT_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic head_valid_i,
    input wire logic retry_i,
    input wire logic short_sel_i,
    output logic expire_o
);

    bdtc_pkg::bdtc_timer_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] limit_m1;

    // length can change mid-count, so compare with >= rather than ==
    assign limit_m1 = short_sel_i ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);

    // ------------------------------------------------------------
    // timer: counts while the delayed completion waits at the head
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= bdtc_pkg::BDTC_IDLE;
            cnt <= '0;
            expire_o <= 1'b0;
        end else if (ce_i) begin
            expire_o <= 1'b0;
            case (state)
                bdtc_pkg::BDTC_IDLE: begin
                    cnt <= '0;
                    if (head_valid_i && !retry_i) begin
                        state <= bdtc_pkg::BDTC_COUNT;
                        cnt <= CNT_W'(1);
                    end
                end
                bdtc_pkg::BDTC_COUNT: begin
                    if (retry_i || !head_valid_i) begin
                        state <= bdtc_pkg::BDTC_IDLE;
                        cnt <= '0;
                    end else if (cnt >= limit_m1) begin
                        state <= bdtc_pkg::BDTC_EXPIRED;
                        expire_o <= 1'b1;
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
                bdtc_pkg::BDTC_EXPIRED: begin
                    // one discard per waiting completion; rearm once it leaves the head
                    if (!head_valid_i) begin
                        state <= bdtc_pkg::BDTC_IDLE;
                    end
                    cnt <= '0;
                end
                default: begin
                    state <= bdtc_pkg::BDTC_IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

endmodule : bdtc_discard_timer

// file: bdtc_err_sink.sv
`timescale 1ns/100ps

// upstream port model: each one-cycle pulse is one message
module bdtc_err_sink (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic nonfatal_i,
    input wire logic fatal_i,
    output int n_nonfatal_o,
    output int n_fatal_o
);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            n_nonfatal_o <= 0;
            n_fatal_o <= 0;
        end else begin
            n_nonfatal_o <= n_nonfatal_o + int'(nonfatal_i);
            n_fatal_o <= n_fatal_o + int'(fatal_i);
        end
    end
endmodule : bdtc_err_sink

// file: bdtc_pkg.sv
package bdtc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] BRIDGE_EXTENDED_CONTROL_OFFSET = 12'h03E;
    localparam logic [15:0] BRIDGE_EXTENDED_CONTROL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // field positions in bridge_extended_control
    // ------------------------------------------------------------
    localparam int RSVD_MSB = 15;
    localparam int RSVD_LSB = 12;
    localparam int DISCARD_ERROR_REPORT_EN_BIT = 11;
    localparam int DISCARD_EXPIRED_FLAG_BIT = 10;
    localparam int SECONDARY_DISCARD_LENGTH_SEL_BIT = 9;
    localparam int UPPER_BYTE_LANE = 1;

    // ------------------------------------------------------------
    // field reset values
    // ------------------------------------------------------------
    localparam logic DISCARD_ERROR_REPORT_EN_RESET = 1'b0;
    localparam logic DISCARD_EXPIRED_FLAG_RESET = 1'b0;
    localparam logic SECONDARY_DISCARD_LENGTH_SEL_RESET = 1'b0;

    // ------------------------------------------------------------
    // discard timer lengths, in clock cycles
    // ------------------------------------------------------------
    localparam int DISCARD_LONG_CYCLES = 32768;
    localparam int DISCARD_SHORT_CYCLES = 1024;
    localparam int DISCARD_CNT_W = 16;

    // ------------------------------------------------------------
    // timer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BDTC_IDLE = 3'b001,
        BDTC_COUNT = 3'b010,
        BDTC_EXPIRED = 3'b100
    } bdtc_timer_state_e;

endpackage : bdtc_pkg

// file: bdtc_properties.sv
`timescale 1ns/100ps

module bdtc_checker #(
    parameter bit AER_PRESENT = 1'b1,
    parameter int LONG_CYCLES = 32768,
    parameter int SHORT_CYCLES = 1024
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic cfg_rd_i,
    input wire logic [15:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic head_valid_i,
    input wire logic retry_i,
    input wire logic discard_o,
    input wire logic conv_pci_mode_i,
    input wire logic aer_discard_mask_i,
    input wire logic aer_severity_fatal_i,
    input wire logic err_nonfatal_o,
    input wire logic err_fatal_o,
    input wire logic discard_error_report_en_o,
    input wire logic secondary_discard_length_sel_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------
    // cycles the head entry has waited without a retry
    // ------------------------------------------------------------
    int run;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run <= 0;
        end else if (ce_i) begin
            run <= (head_valid_i && !retry_i) ? run + 1 : 0;
        end
    end
    sequence seq_wr_taken;
        ce_i && cfg_wr_i && cfg_addr_i == 12'h03E && cfg_be_i[1];
    endsequence
    sequence seq_quiet;
        !err_nonfatal_o && !err_fatal_o;
    endsequence
    chk_rsvd_zero: assert property (cfg_rvalid_o |-> cfg_rdata_o[15:12] == 4'h0)
        else $error("reserved bits read nonzero");
    chk_read_answer: assert property (ce_i && cfg_rd_i |=> cfg_rvalid_o)
        else $error("read not answered");
    chk_discard_len: assert property (
        discard_o |-> run == (secondary_discard_length_sel_o ? SHORT_CYCLES : LONG_CYCLES))
        else $error("discard at wrong count");
    chk_err_cause: assert property (err_nonfatal_o || err_fatal_o |-> $past(discard_o))
        else $error("message without discard");
    chk_err_sent: assert property (
        discard_o && conv_pci_mode_i && discard_error_report_en_o |=> err_nonfatal_o != err_fatal_o)
        else $error("enabled discard sent no message");
    chk_err_silent: assert property (
        discard_o && (aer_discard_mask_i || !AER_PRESENT) && !(conv_pci_mode_i && discard_error_report_en_o)
        |=> seq_quiet)
        else $error("message while reporting off");
    chk_err_severity: assert property (
        err_nonfatal_o || err_fatal_o |-> err_fatal_o == (AER_PRESENT && $past(aer_severity_fatal_i)))
        else $error("wrong message severity");
    chk_ctrl_mirror: assert property (
        seq_wr_taken |=> ##1 discard_error_report_en_o == $past(cfg_wdata_i[11], 2)
        && secondary_discard_length_sel_o == $past(cfg_wdata_i[9], 2))
        else $error("control copy not updated");
endmodule : bdtc_checker

// file: bdtc_top.sv
`timescale 1ns/100ps


module bdtc_top #(
    parameter bit AER_PRESENT = 1'b1,
    parameter int LONG_CYCLES = bdtc_pkg::DISCARD_LONG_CYCLES,
    parameter int SHORT_CYCLES = bdtc_pkg::DISCARD_SHORT_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // configuration access
    input wire logic [11:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic cfg_rd_i,
    output logic [15:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // delayed transaction queue
    input wire logic head_valid_i,
    input wire logic retry_i,
    output logic discard_o,
    // mode and advanced error reporting
    input wire logic conv_pci_mode_i,
    input wire logic aer_discard_mask_i,
    input wire logic aer_severity_fatal_i,
    // upstream error messages
    output logic err_nonfatal_o,
    output logic err_fatal_o,
    // control state seen by the rest of the bridge
    output logic discard_error_report_en_o,
    output logic secondary_discard_length_sel_o
);

    // ------------------------------------------------------------
    // register state and decode
    // ------------------------------------------------------------
    logic discard_error_report_en;
    logic discard_expired_flag;
    logic secondary_discard_length_sel;
    logic reg_hit;
    logic wr_upper;
    logic clear_req;
    logic expire;
    logic report_ok;
    logic [15:0] read_value;

    always_comb begin
        if (cfg_addr_i == bdtc_pkg::BRIDGE_EXTENDED_CONTROL_OFFSET) begin
            reg_hit = 1'b1;
        end else begin
            reg_hit = 1'b0;
        end
    end

    // every writable bit sits in the upper byte lane
    assign wr_upper = cfg_wr_i && reg_hit && cfg_be_i[bdtc_pkg::UPPER_BYTE_LANE];
    assign clear_req = wr_upper && cfg_wdata_i[bdtc_pkg::DISCARD_EXPIRED_FLAG_BIT];

    // ------------------------------------------------------------
    // discard timer
    // ------------------------------------------------------------
    bdtc_discard_timer #(
        .CNT_W(bdtc_pkg::DISCARD_CNT_W),
        .LONG_CYCLES(LONG_CYCLES),
        .SHORT_CYCLES(SHORT_CYCLES)
    ) u_timer (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .head_valid_i(head_valid_i),
        .retry_i(retry_i),
        .short_sel_i(secondary_discard_length_sel),
        .expire_o(expire)
    );

    // the timer's pulse is already a flop; it doubles as the discard command
    assign discard_o = expire;

    // ------------------------------------------------------------
    // read/write control bits
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            discard_error_report_en <= bdtc_pkg::DISCARD_ERROR_REPORT_EN_RESET;
        end else if (ce_i && wr_upper) begin
            discard_error_report_en <= cfg_wdata_i[bdtc_pkg::DISCARD_ERROR_REPORT_EN_BIT];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            secondary_discard_length_sel <= bdtc_pkg::SECONDARY_DISCARD_LENGTH_SEL_RESET;
        end else if (ce_i && wr_upper) begin
            secondary_discard_length_sel <= cfg_wdata_i[bdtc_pkg::SECONDARY_DISCARD_LENGTH_SEL_BIT];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            discard_error_report_en_o <= bdtc_pkg::DISCARD_ERROR_REPORT_EN_RESET;
            secondary_discard_length_sel_o <= bdtc_pkg::SECONDARY_DISCARD_LENGTH_SEL_RESET;
        end else if (ce_i) begin
            discard_error_report_en_o <= discard_error_report_en;
            secondary_discard_length_sel_o <= secondary_discard_length_sel;
        end
    end

    // ------------------------------------------------------------
    // sticky expiry flag
    // ------------------------------------------------------------
    // set is tested first so an expiry in the clearing cycle is never lost
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            discard_expired_flag <= bdtc_pkg::DISCARD_EXPIRED_FLAG_RESET;
        end else if (ce_i) begin
            if (expire) begin
                discard_expired_flag <= 1'b1;
            end else if (clear_req) begin
                discard_expired_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // upstream error message
    // ------------------------------------------------------------
    // enable only counts in conventional mode; the unmasked advanced path stands on its own
    assign report_ok = (conv_pci_mode_i && discard_error_report_en)
                       || (AER_PRESENT && !aer_discard_mask_i);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_nonfatal_o <= 1'b0;
            err_fatal_o <= 1'b0;
        end else if (ce_i) begin
            err_nonfatal_o <= 1'b0;
            err_fatal_o <= 1'b0;
            if (expire && report_ok) begin
                // without advanced reporting the severity select is ignored
                if (AER_PRESENT && aer_severity_fatal_i) begin
                    err_fatal_o <= 1'b1;
                end else begin
                    err_nonfatal_o <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        read_value = 16'h0000;
        if (reg_hit) begin
            read_value[bdtc_pkg::DISCARD_ERROR_REPORT_EN_BIT] = discard_error_report_en;
            read_value[bdtc_pkg::DISCARD_EXPIRED_FLAG_BIT] = discard_expired_flag;
            read_value[bdtc_pkg::SECONDARY_DISCARD_LENGTH_SEL_BIT] = secondary_discard_length_sel;
        end
    end

    // reads have one cycle of latency and no side effects
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_rdata_o <= 16'h0000;
            cfg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= read_value;
            end
        end
    end

endmodule : bdtc_top

// file: testbench.sv
`timescale 1ns/100ps

module testbench;
    localparam int LONG = 64;
    localparam int SHORT = 8;
    logic clk, rst_b, ce, wr, rd, head, retry, conv, mask, sev;
    logic [11:0] addr;
    logic [1:0] be;
    logic [15:0] wdata, rdata, ctrl;
    logic rvalid, discard, nf, ft, en_o, sel_o;
    int n_nf, n_ft, num_errors, n_compared;
    bdtc_top #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) bdtc_top_inst (.core_clk_i(clk), .rst_b_i(rst_b),
        .ce_i(ce), .cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rd_i(rd),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .head_valid_i(head), .retry_i(retry), .discard_o(discard),
        .conv_pci_mode_i(conv), .aer_discard_mask_i(mask), .aer_severity_fatal_i(sev), .err_nonfatal_o(nf),
        .err_fatal_o(ft), .discard_error_report_en_o(en_o), .secondary_discard_length_sel_o(sel_o));
    bdtc_err_sink bdtc_err_sink_inst (.core_clk_i(clk), .rst_b_i(rst_b), .nonfatal_i(nf), .fatal_i(ft),
        .n_nonfatal_o(n_nf), .n_fatal_o(n_ft));
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [1:0] b, input logic [15:0] d);
        be = b;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [15:0] exp);
        rd = 1'b1;
        tick();
        rd = 1'b0;
        check("rvalid", rvalid, 1);
        check("rdata", rdata, exp);
    endtask : rd_chk
    // the flag clear lands on the very edge that sets it, so the set must win
    // pre above zero lets the head wait pre cycles, then a retry restarts the count
    task automatic expire(input int len, input int enf, input int eft, input int pre);
        int c;
        int nf0;
        int ft0;
        nf0 = n_nf;
        ft0 = n_ft;
        c = 0;
        wr_reg(2'b10, ctrl);
        head = 1'b1;
        if (pre > 0) begin
            repeat (pre) tick();
            retry = 1'b1;
            tick();
            retry = 1'b0;
        end
        while (discard !== 1'b1 && c < 100) begin
            tick();
            c++;
        end
        head = 1'b0;
        check("length", c, len);
        wr_reg(2'b10, ctrl | 16'h0400);
        check("discard_pulse", discard, 0);
        tick();
        tick();
        check("nonfatal", n_nf - nf0, enf);
        check("fatal", n_ft - ft0, eft);
        rd_chk(ctrl | 16'h0400);
        wr_reg(2'b10, ctrl | 16'h0400);
        rd_chk(ctrl);
    endtask : expire
    task automatic test_reg_access();
        rd_chk(16'h0000);
        wr_reg(2'b11, 16'hFFFF);
        rd_chk(16'h0A00);
        check("report_en_copy", en_o, 1);
        check("length_sel_copy", sel_o, 1);
        wr_reg(2'b01, 16'h0000);
        rd_chk(16'h0A00);
    endtask : test_reg_access
    task automatic test_report_sent();
        conv = 1'b1;
        ctrl = 16'h0A00;
        expire(SHORT, 1, 0, 0);
        sev = 1'b1;
        expire(SHORT, 0, 1, 0);
        sev = 1'b0;
        ctrl = 16'h0800;
        expire(LONG, 1, 0, 0);
    endtask : test_report_sent
    task automatic test_report_blocked();
        conv = 1'b0;
        ctrl = 16'h0A00;
        expire(SHORT, 0, 0, 0);
        conv = 1'b1;
        ctrl = 16'h0200;
        expire(SHORT, 0, 0, 0);
    endtask : test_report_blocked
    task automatic test_aer_path();
        conv = 1'b1;
        ctrl = 16'h0200;
        mask = 1'b0;
        expire(SHORT, 1, 0, 0);
    endtask : test_aer_path
    // without the restart the discard would come after only a few cycles
    task automatic test_retry_restart();
        conv = 1'b1;
        ctrl = 16'h0200;
        mask = 1'b0;
        expire(SHORT, 1, 0, 5);
    endtask : test_retry_restart
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        print_verdict();
    end
    initial begin
        {rst_b, wr, rd, head, retry, conv, sev, be, wdata} = '0;
        ce = 1'b1;
        mask = 1'b1;
        addr = 12'h03E;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        tick();
        test_reg_access();
        test_report_sent();
        test_report_blocked();
        test_aer_path();
        test_retry_restart();
        print_verdict();
    end
endmodule : testbench

bind bdtc_top bdtc_checker #(.AER_PRESENT(AER_PRESENT), .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES))
    bdtc_checker_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cfg_addr_i(cfg_addr_i),
        .cfg_wr_i(cfg_wr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rd_i(cfg_rd_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .head_valid_i(head_valid_i), .retry_i(retry_i),
        .discard_o(discard_o), .conv_pci_mode_i(conv_pci_mode_i), .aer_discard_mask_i(aer_discard_mask_i),
        .aer_severity_fatal_i(aer_severity_fatal_i), .err_nonfatal_o(err_nonfatal_o), .err_fatal_o(err_fatal_o),
        .discard_error_report_en_o(discard_error_report_en_o),
        .secondary_discard_length_sel_o(secondary_discard_length_sel_o));
